// ==== nesc_regs.svh ====
// constants for the nand erase / reset / feature command controller
// assumes a 125 MHz system clock; included by the pin cycle, host and bench files
`ifndef NESC_REGS_SVH
`define NESC_REGS_SVH
// ==========================================================
// software register offsets (byte addresses)
`define NESC_REG_CTRL       8'h00
`define NESC_REG_ROW0       8'h04
`define NESC_REG_ROW1       8'h08
`define NESC_REG_FADDR      8'h0c
`define NESC_REG_FDATA      8'h10
`define NESC_REG_STATUS     8'h14
`define NESC_REG_CFG        8'h18
// status register fields
`define NESC_ST_BUSY        0
`define NESC_ST_DONE        1
`define NESC_ST_REFUSED     2
`define NESC_CFG_WP_RESET   1'b1
// ==========================================================
// command codes on the flash bus
`define NESC_CMD_ERASE_SETUP   8'h60
`define NESC_CMD_ERASE_CONFIRM 8'hd0
`define NESC_CMD_DUAL_QUEUE    8'hd1
`define NESC_CMD_RESET         8'hff
`define NESC_CMD_STATUS        8'h70
`define NESC_CMD_STATUS_ENH    8'h78
`define NESC_CMD_GET_FEAT      8'hee
`define NESC_CMD_SET_FEAT      8'hef
`define NESC_FEAT_DRIVE        8'h80
`define NESC_FEAT_PULLDOWN     8'h81
// ==========================================================
// row address layout: page, plane select, block
`define NESC_BLOCKS         2048
`define NESC_PAGES          64
`define NESC_PAGE_BITS      6
`define NESC_PLANE_BIT      6
`define NESC_BLOCK_BITS     11
`define NESC_ROW_W          18
`define NESC_ST_FAIL_BIT    0
`define NESC_ST_READY_BIT   6
// ==========================================================
// bus timing, least times rounded up to whole cycles
`define NESC_CLK_NS         8
`define NESC_T_WP_NS        12
`define NESC_T_WH_NS        10
`define NESC_T_ADL_NS       70
`define NESC_T_WB_NS        100
`define NESC_WP_CYC  ((`NESC_T_WP_NS + `NESC_CLK_NS - 1) / `NESC_CLK_NS)
`define NESC_WH_CYC  ((`NESC_T_WH_NS + `NESC_CLK_NS - 1) / `NESC_CLK_NS)
`define NESC_ADL_CYC ((`NESC_T_ADL_NS + `NESC_CLK_NS - 1) / `NESC_CLK_NS)
`define NESC_WB_CYC  ((`NESC_T_WB_NS + `NESC_CLK_NS - 1) / `NESC_CLK_NS)
`endif

// ==== nesc_pkg.sv ====
// types shared by the flash command controller files
// assumes nesc_regs.svh holds the numeric constants
package nesc_pkg;
  // software-visible operation codes
  typedef enum logic [2:0] {
    NESC_OP_NONE   = 3'h0,
    NESC_OP_ERASE1 = 3'h1,
    NESC_OP_ERASE2 = 3'h2,
    NESC_OP_RESET  = 3'h3,
    NESC_OP_GETF   = 3'h4,
    NESC_OP_SETF   = 3'h5,
    NESC_OP_STAT   = 3'h6,
    NESC_OP_STATE  = 3'h7
  } nesc_op_e;
  // kind of one step of a command sequence
  typedef enum logic [2:0] {
    K_CMD = 3'h0, K_ADDR = 3'h1, K_WDAT = 3'h2, K_RDAT = 3'h3,
    K_RSTAT = 3'h4, K_WAIT = 3'h5, K_END = 3'h6
  } nesc_kind_e;
  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_ISSUE = 4'b0010,
    S_XFER  = 4'b0100,
    S_WAIT  = 4'b1000
  } nesc_state_e;
  typedef struct packed {
    nesc_kind_e kind;
    logic [7:0] data;
  } nesc_step_s;
endpackage

// ==== nesc_pin_cycle.sv ====
// one flash bus cycle: command, address, data write or data read
// assumes io input is synchronous to i_clock and sampled at the end of re low
`timescale 1ns/1ns
`include "nesc_regs.svh"
module nesc_pin_cycle import nesc_pkg::*; #(
  parameter int WP_CYC  = `NESC_WP_CYC,
  parameter int WH_CYC  = `NESC_WH_CYC,
  parameter int ADL_CYC = `NESC_ADL_CYC
) (
  input  wire logic       i_clock,
  input  wire logic       i_rstn,
  input  wire logic       i_start,
  input  nesc_kind_e      i_kind,
  input  wire logic [7:0] i_byte,
  input  wire logic [7:0] i_io_in,
  output logic            o_done,
  output logic [7:0]      o_rbyte,
  output logic            o_cle,
  output logic            o_ale,
  output logic            o_we_n,
  output logic            o_re_n,
  output logic [7:0]      o_io_out,
  output logic            o_io_oe
);
  // ==========================================================
  // parameter check
  if (WP_CYC < 1 || WP_CYC > 255 || WH_CYC < 1 || WH_CYC > 255 ||
      ADL_CYC < 1 || ADL_CYC > 255) begin : g_bad
    $error("nesc_pin_cycle: phase counts must be 1..255");
  end

  logic       active_q;
  logic       high_q;
  logic [7:0] cnt_q;
  logic       write_q;
  logic       low_end;
  logic       is_wr;

  assign is_wr   = (i_kind == K_CMD) || (i_kind == K_ADDR) || (i_kind == K_WDAT);
  assign low_end = active_q && !high_q && (cnt_q == 8'h00);
  assign o_done  = active_q && high_q && (cnt_q == 8'h00);

  // ==========================================================
  // phase counter: strobe low phase, then recovery high phase
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      active_q <= 1'b0;
      high_q   <= 1'b0;
      cnt_q    <= 8'h00;
      write_q  <= 1'b0;
    end else if (!active_q) begin
      if (i_start) begin
        active_q <= 1'b1;
        high_q   <= 1'b0;
        cnt_q    <= 8'(WP_CYC - 1);
        write_q  <= is_wr;
      end
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end else if (!high_q) begin
      high_q <= 1'b1;
      // address-to-data gap is kept after every address cycle
      cnt_q  <= o_ale ? 8'(ADL_CYC - 1) : 8'(WH_CYC - 1);
    end else begin
      active_q <= 1'b0;
    end
  end

  // pins are flops so the flash never sees glitches
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cle    <= 1'b0;
      o_ale    <= 1'b0;
      o_we_n   <= 1'b1;
      o_re_n   <= 1'b1;
      o_io_out <= 8'h00;
      o_io_oe  <= 1'b0;
    end else if (!active_q && i_start) begin
      o_cle    <= (i_kind == K_CMD);
      o_ale    <= (i_kind == K_ADDR);
      o_we_n   <= !is_wr;
      o_re_n   <= is_wr;
      o_io_out <= i_byte;
      o_io_oe  <= is_wr;
    end else if (low_end) begin
      o_we_n <= 1'b1;
      o_re_n <= 1'b1;
    end else if (o_done) begin
      o_cle   <= 1'b0;
      o_ale   <= 1'b0;
      o_io_oe <= 1'b0;
    end
  end

  // read byte caught as re rises
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rbyte <= 8'h00;
    end else if (low_end && !write_q) begin
      o_rbyte <= i_io_in;
    end
  end

  // ==========================================================
  // checks
  a_strobe_excl: assert property (@(posedge i_clock) disable iff (!i_rstn)
    !(o_cle && o_ale) && !(!o_we_n && !o_re_n))
    else $error("cle/ale or we/re asserted together");
  a_we_width: assert property (@(posedge i_clock) disable iff (!i_rstn)
    $fell(o_we_n) |=> !o_we_n ##1 o_we_n)
    else $error("write strobe low width wrong");
endmodule // nesc_pin_cycle

// ==== nesc_host.sv ====
// host-side sequencer for flash block erase, reset and feature commands
// assumes a software port with one-cycle strobes and a flash on the pins
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`include "nesc_regs.svh"
module nesc_host import nesc_pkg::*; #(
  parameter int PAGE_BITS  = `NESC_PAGE_BITS,
  parameter int BLOCK_BITS = `NESC_BLOCK_BITS,
  parameter int WB_CYC     = `NESC_WB_CYC
) (
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  output logic             o_ce_n,
  output logic             o_cle,
  output logic             o_ale,
  output logic             o_we_n,
  output logic             o_re_n,
  output logic             o_wp_n,
  output logic [7:0]       o_io_out,
  output logic             o_io_oe,
  input  wire logic [7:0]  i_io_in,
  input  wire logic        i_ready_busy_n
);
  // ==========================================================
  // parameter check
  if ((1 << PAGE_BITS) != `NESC_PAGES || (1 << BLOCK_BITS) != `NESC_BLOCKS ||
      PAGE_BITS + 1 + BLOCK_BITS != `NESC_ROW_W || WB_CYC < 1 || WB_CYC > 255)
  begin : g_bad
    $error("nesc_host: row layout or wait count unsupported");
  end

  localparam int RW = `NESC_ROW_W;

  nesc_state_e   state_q;
  nesc_op_e      op_q;
  nesc_op_e      new_op;
  nesc_step_s    cur;
  logic [3:0]    step_q;
  logic [7:0]    wb_q;
  logic [RW-1:0] row0_q, row1_q, row0_eff, row1_eff;
  logic [7:0]    faddr_q, stat_q, rbyte, last_cmd_q;
  logic [31:0]   fdata_q, fdata_eff, cap_q;
  logic          done_q, refused_q, accept, cmd_wr, eng_start, eng_done;
  logic [2:0]    wcount_q;

  // ==========================================================
  // step decode helpers
  function automatic logic [7:0] row_byte(input logic [RW-1:0] r, input logic [1:0] i);
    case (i)
      2'h0:    row_byte = r[7:0];
      2'h1:    row_byte = r[15:8];
      default: row_byte = {6'h00, r[17:16]};
    endcase
  endfunction

  function automatic nesc_step_s mk(input nesc_kind_e k, input logic [7:0] d);
    mk.kind = k;
    mk.data = d;
  endfunction

  // one table drives every sequence, so ordering lives in one place
  function automatic nesc_step_s step_of(input nesc_op_e op, input logic [3:0] s,
      input logic [RW-1:0] r0, input logic [RW-1:0] r1, input logic [7:0] fa,
      input logic [31:0] fd);
    step_of = mk(K_END, 8'h00);
    case (op)
      NESC_OP_ERASE1, NESC_OP_ERASE2: begin
        case (s)
          4'h0, 4'h6:       step_of = mk(s == 4'h0 || op == NESC_OP_ERASE2 ?
                                         K_CMD : K_CMD, s == 4'h0 || op == NESC_OP_ERASE2
                                         ? `NESC_CMD_ERASE_SETUP : `NESC_CMD_STATUS);
          4'h1, 4'h2, 4'h3: step_of = mk(K_ADDR, row_byte(r0, 2'(s - 4'h1)));
          4'h4:             step_of = mk(K_CMD, op == NESC_OP_ERASE2 ?
                                         `NESC_CMD_DUAL_QUEUE : `NESC_CMD_ERASE_CONFIRM);
          4'h5, 4'hb:       step_of = mk(K_WAIT, 8'h00);
          4'h7:             step_of = mk(op == NESC_OP_ERASE2 ? K_ADDR : K_RSTAT,
                                         row_byte(r1, 2'h0));
          4'h8, 4'h9:       step_of = mk(op == NESC_OP_ERASE2 ? K_ADDR : K_END,
                                         row_byte(r1, 2'(s - 4'h7)));
          4'ha:             step_of = mk(op == NESC_OP_ERASE2 ? K_CMD : K_END,
                                         `NESC_CMD_ERASE_CONFIRM);
          4'hc:             step_of = mk(op == NESC_OP_ERASE2 ? K_CMD : K_END,
                                         `NESC_CMD_STATUS);
          4'hd:             step_of = mk(op == NESC_OP_ERASE2 ? K_RSTAT : K_END, 8'h00);
          default:          step_of = mk(K_END, 8'h00);
        endcase
      end
      NESC_OP_RESET: begin
        case (s)
          4'h0:    step_of = mk(K_CMD, `NESC_CMD_RESET);
          4'h1:    step_of = mk(K_WAIT, 8'h00);
          4'h2:    step_of = mk(K_CMD, `NESC_CMD_STATUS);
          4'h3:    step_of = mk(K_RSTAT, 8'h00);
          default: step_of = mk(K_END, 8'h00);
        endcase
      end
      NESC_OP_GETF, NESC_OP_SETF: begin
        if (s == 4'h0) begin
          step_of = mk(K_CMD, op == NESC_OP_GETF ? `NESC_CMD_GET_FEAT : `NESC_CMD_SET_FEAT);
        end else if (s == 4'h1) begin
          step_of = mk(K_ADDR, fa);
        end else if (op == NESC_OP_GETF) begin
          if (s == 4'h2) step_of = mk(K_WAIT, 8'h00);
          else if (s <= 4'h6) step_of = mk(K_RDAT, 8'h00);
        end else begin
          if (s <= 4'h5) step_of = mk(K_WDAT, fd[8*(2'(s - 4'h2)) +: 8]);
          else if (s == 4'h6) step_of = mk(K_WAIT, 8'h00);
        end
      end
      NESC_OP_STAT, NESC_OP_STATE: begin
        if (s == 4'h0) begin
          step_of = mk(K_CMD, op == NESC_OP_STAT ? `NESC_CMD_STATUS : `NESC_CMD_STATUS_ENH);
        end else if (op == NESC_OP_STATE && s <= 4'h3) begin
          step_of = mk(K_ADDR, row_byte(r0, 2'(s - 4'h1)));
        end else if (s == (op == NESC_OP_STAT ? 4'h1 : 4'h4)) begin
          step_of = mk(K_RSTAT, 8'h00);
        end
      end
      default: step_of = mk(K_END, 8'h00);
    endcase
  endfunction

  // ==========================================================
  // address shaping: page bits go out untouched, plane bit forced for dual-plane erase
  always_comb begin
    row0_eff = row0_q;
    row1_eff = row1_q;
    if (op_q == NESC_OP_ERASE2) begin
      row0_eff[`NESC_PLANE_BIT] = 1'b0;
      row1_eff[`NESC_PLANE_BIT] = 1'b1;
    end
    // known feature slots carry only two live bits
    fdata_eff = fdata_q;
    if (faddr_q == `NESC_FEAT_DRIVE || faddr_q == `NESC_FEAT_PULLDOWN)
      fdata_eff = {30'h0, fdata_q[1:0]};
  end

  assign cur    = step_of(op_q, step_q, row0_eff, row1_eff, faddr_q, fdata_eff);
  assign cmd_wr = i_wr && (i_addr == `NESC_REG_CTRL);
  assign new_op = nesc_op_e'(i_wdata[2:0]);
  // only a reset may break into a busy wait
  assign accept = cmd_wr && (new_op != NESC_OP_NONE) && ((state_q == S_IDLE) ||
                  (state_q == S_WAIT && new_op == NESC_OP_RESET));
  assign eng_start = (state_q == S_ISSUE) && (cur.kind != K_WAIT) && (cur.kind != K_END);

  // ==========================================================
  // sequencer
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= S_IDLE;
      op_q    <= NESC_OP_NONE;
      step_q  <= 4'h0;
      wb_q    <= 8'h00;
    end else if (accept) begin
      op_q    <= new_op;
      step_q  <= 4'h0;
      state_q <= S_ISSUE;
    end else begin
      case (state_q)
        S_IDLE: state_q <= S_IDLE;
        S_ISSUE: begin
          if (cur.kind == K_END) state_q <= S_IDLE;
          else if (cur.kind == K_WAIT) begin
            state_q <= S_WAIT;
            wb_q    <= 8'(WB_CYC - 1);
          end else state_q <= S_XFER;
        end
        S_XFER: begin
          if (eng_done) begin
            step_q  <= step_q + 4'h1;
            state_q <= S_ISSUE;
          end
        end
        S_WAIT: begin
          // busy may rise late, so ready is trusted only after the gap
          if (wb_q != 8'h00) wb_q <= wb_q - 8'h01;
          else if (i_ready_busy_n) begin
            step_q  <= step_q + 4'h1;
            state_q <= S_ISSUE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  nesc_pin_cycle u_cycle (
    .i_clock  (i_clock),
    .i_rstn   (i_rstn),
    .i_start  (eng_start),
    .i_kind   (cur.kind),
    .i_byte   (cur.data),
    .i_io_in  (i_io_in),
    .o_done   (eng_done),
    .o_rbyte  (rbyte),
    .o_cle    (o_cle),
    .o_ale    (o_ale),
    .o_we_n   (o_we_n),
    .o_re_n   (o_re_n),
    .o_io_out (o_io_out),
    .o_io_oe  (o_io_oe)
  );

  // captured results: parameters shift in P1 first, status byte alone
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cap_q  <= 32'h0000_0000;
      stat_q <= 8'h00;
    end else if (state_q == S_XFER && eng_done) begin
      if (cur.kind == K_RDAT) cap_q <= {rbyte, cap_q[31:8]};
      if (cur.kind == K_RSTAT) stat_q <= rbyte;
    end
  end

  // done and refused flags; set and clear never share a cycle for done
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      done_q    <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      if (accept) done_q <= 1'b0;
      else if (state_q == S_ISSUE && cur.kind == K_END) done_q <= 1'b1;
      if (cmd_wr && !accept) refused_q <= 1'b1;
      else if (i_wr && i_addr == `NESC_REG_STATUS && i_wdata[`NESC_ST_REFUSED])
        refused_q <= 1'b0;
    end
  end

  // ==========================================================
  // software registers; chip enable held low after reset
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      row0_q  <= '0;
      row1_q  <= '0;
      faddr_q <= 8'h00;
      fdata_q <= 32'h0000_0000;
      o_wp_n  <= `NESC_CFG_WP_RESET;
      o_ce_n  <= 1'b1;
    end else begin
      o_ce_n <= 1'b0;
      if (i_wr && i_addr == `NESC_REG_ROW0)  row0_q  <= i_wdata[RW-1:0];
      if (i_wr && i_addr == `NESC_REG_ROW1)  row1_q  <= i_wdata[RW-1:0];
      if (i_wr && i_addr == `NESC_REG_FADDR) faddr_q <= i_wdata[7:0];
      if (i_wr && i_addr == `NESC_REG_FDATA) fdata_q <= i_wdata;
      if (i_wr && i_addr == `NESC_REG_CFG)   o_wp_n  <= i_wdata[0];
    end
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        `NESC_REG_CTRL:   o_rdata <= {29'h0, op_q};
        `NESC_REG_ROW0:   o_rdata <= {14'h0, row0_q};
        `NESC_REG_ROW1:   o_rdata <= {14'h0, row1_q};
        `NESC_REG_FADDR:  o_rdata <= {24'h0, faddr_q};
        `NESC_REG_FDATA:  o_rdata <= cap_q;
        `NESC_REG_STATUS: o_rdata <= {15'h0, i_ready_busy_n, stat_q, 5'h0, refused_q,
                                      done_q, state_q != S_IDLE};
        `NESC_REG_CFG:    o_rdata <= {31'h0, o_wp_n};
        default:          o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // helpers for the checks
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      last_cmd_q <= 8'h00;
      wcount_q   <= 3'h0;
    end else begin
      if (eng_start && cur.kind == K_CMD) last_cmd_q <= cur.data;
      if (accept) wcount_q <= 3'h0;
      else if (eng_start && cur.kind == K_WDAT) wcount_q <= wcount_q + 3'h1;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  a_erase_confirm: assert property (
    (eng_start && op_q == NESC_OP_ERASE1 && step_q == 4'h4) |->
      cur.data == `NESC_CMD_ERASE_CONFIRM ##[4:8] state_q == S_WAIT)
    else $error("single erase not confirmed then waited");
  a_queue_code: assert property (
    (eng_start && op_q == NESC_OP_ERASE2 && step_q == 4'h4) |->
      cur.data == `NESC_CMD_DUAL_QUEUE ##[4:8] state_q == S_WAIT)
    else $error("queue step did not send d1 then wait");
  a_second_ready: assert property (
    (eng_start && op_q == NESC_OP_ERASE2 && step_q == 4'h6) |-> i_ready_busy_n)
    else $error("second erase issued while busy");
  a_plane_low: assert property (
    (eng_start && op_q == NESC_OP_ERASE2 && step_q == 4'h1) |-> !cur.data[6])
    else $error("first row plane bit not low");
  a_plane_high: assert property (
    (eng_start && op_q == NESC_OP_ERASE2 && step_q == 4'h7) |-> cur.data[6])
    else $error("second row plane bit not high");
  a_status_after: assert property (
    (state_q == S_ISSUE && cur.kind == K_END &&
     (op_q == NESC_OP_ERASE1 || op_q == NESC_OP_ERASE2)) |->
      last_cmd_q == `NESC_CMD_STATUS ##1 done_q)
    else $error("erase ended without status read");
  a_four_params: assert property (
    (state_q == S_ISSUE && cur.kind == K_WAIT && op_q == NESC_OP_SETF) |-> wcount_q == 3'h4)
    else $error("set features did not send four bytes");
  a_get_ready: assert property (
    (eng_start && cur.kind == K_RDAT) |-> i_ready_busy_n)
    else $error("feature read while busy");
  a_busy_status: assert property (
    (eng_start && !i_ready_busy_n) |-> cur.kind == K_CMD &&
      (cur.data == `NESC_CMD_RESET || cur.data == `NESC_CMD_STATUS))
    else $error("array command while flash busy");
  a_one_type: assert property (
    (state_q != S_IDLE && $past(state_q) != S_IDLE && !$past(accept)) |-> $stable(op_q))
    else $error("operation changed mid sequence");

  c_erase1: cover property (state_q == S_ISSUE && cur.kind == K_END && op_q == NESC_OP_ERASE1);
  c_erase2: cover property (state_q == S_ISSUE && cur.kind == K_END && op_q == NESC_OP_ERASE2);
  c_abort:  cover property (accept && state_q == S_WAIT);
  c_setf:   cover property (state_q == S_ISSUE && cur.kind == K_END && op_q == NESC_OP_SETF);
endmodule // nesc_host

// ==== nesc_flash_model.sv ====
// behavioural flash device: erase, reset, status and feature commands
// assumes host strobes synchronous to i_clock; bytes latched on we_n rise
`timescale 1ns/1ns
module nesc_flash_model #(
  parameter int T_BUSY = 20
) (
  input  wire logic       i_clock,
  input  wire logic       i_cle,
  input  wire logic       i_ale,
  input  wire logic       i_we_n,
  input  wire logic       i_re_n,
  input  wire logic       i_wp_n,
  input  wire logic [7:0] i_io,
  output logic [7:0]      o_io,
  output logic            o_ready_busy_n
);
  // ==========================================================
  // state; feature table only cleared at power-on
  logic        we_q = 1'b1, re_q = 1'b1;
  logic [7:0]  cmd_q = 8'h0, fa_q = 8'h0, st_q = 8'he0, last_q = 8'h0, rb;
  logic [1:0]  n_q = 2'h0, pl_q = 2'h0;
  logic [23:0] row_q = 24'h0;
  logic [31:0] par_q = 32'h0;
  logic [31:0] feat_q [2] = '{32'h0, 32'h0};
  logic [10:0] blk_q = 11'h0;
  int          busy_q = 0;
  assign o_ready_busy_n = (busy_q == 0);
  // byte actions on the rising write strobe
  always @(posedge i_clock) begin
    we_q <= i_we_n;
    re_q <= i_re_n;
    if (busy_q > 0) busy_q <= busy_q - 1;
    if (i_re_n && !re_q) n_q <= n_q + 2'h1;
    if (!i_re_n) last_q <= rb;
    if (i_we_n && !we_q && i_cle) begin
      cmd_q <= i_io;
      n_q <= 2'h0;
      if (i_io == 8'hd1 || i_io == 8'hd0) pl_q <= {pl_q[0], row_q[6]};
      if (i_io == 8'hd1) busy_q <= T_BUSY;
      if (i_io == 8'hff || i_io == 8'hd0) st_q <= {i_wp_n, 7'h60};
      if (i_io == 8'hff) busy_q <= T_BUSY;
      if (i_io == 8'hd0) begin
        busy_q <= 4 * T_BUSY;
        blk_q <= row_q[17:7];
      end
    end else if (i_we_n && !we_q && i_ale) begin
      row_q <= {i_io, row_q[23:8]};
      fa_q <= i_io;
      if (cmd_q == 8'hee) busy_q <= T_BUSY;
    end else if (i_we_n && !we_q && cmd_q == 8'hef) begin
      par_q <= {i_io, par_q[31:8]};
      n_q <= n_q + 2'h1;
      if (n_q == 2'h3) busy_q <= T_BUSY;
      if (n_q == 2'h3 && fa_q[7:1] == 7'h40) feat_q[fa_q[0]] <= {i_io, par_q[31:8]};
    end
  end
  // read byte; a released bus shows the inverse of the last byte
  always_comb begin
    rb = (busy_q != 0) ? (st_q & 8'h9f) : st_q;
    if (cmd_q == 8'hee) rb = (fa_q[7:1] == 7'h40) ? feat_q[fa_q[0]][8*n_q +: 8] : 8'h0;
    o_io = i_re_n ? ~last_q : rb;
  end
endmodule // nesc_flash_model

// ==== tb_nesc_host.sv ====
// self-checking bench for the flash command sequencer
// assumes the behavioural flash model on the far side of the pins
`timescale 1ns/1ns
`include "nesc_regs.svh"
module tb_nesc_host import nesc_pkg::*;;
  // ==========================================================
  logic        i_clock = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0]  i_addr = 8'h0, io_to, io_from, io_w;
  logic [31:0] i_wdata = 32'h0, o_rdata, v, r0, r1;
  logic        cle, ale, we_n, re_n, wp_n, rbn, oe;
  int          err_total = 0, num_checks = 0, seed = 32'h4ab766c1, k;
  always #4 i_clock = ~i_clock;
  // the io wire carries whichever side has it enabled
  assign io_w = oe ? io_to : io_from;
  nesc_host u_nesc_host (.i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_ce_n(),
    .o_cle(cle), .o_ale(ale), .o_we_n(we_n), .o_re_n(re_n), .o_wp_n(wp_n),
    .o_io_out(io_to), .o_io_oe(oe), .i_io_in(io_w), .i_ready_busy_n(rbn));
  nesc_flash_model u_nesc_flash_model (.i_clock(i_clock), .i_cle(cle), .i_ale(ale),
    .i_we_n(we_n), .i_re_n(re_n), .i_wp_n(wp_n), .i_io(io_w), .o_io(io_from),
    .o_ready_busy_n(rbn));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (err_total == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // start an operation and poll busy under a bound
  task automatic run(input nesc_op_e op);
    int n;
    wr(`NESC_REG_CTRL, 32'(op));
    v = 32'h1;
    for (n = 0; n < 2000 && v[0] !== 1'b0; n++) rd(`NESC_REG_STATUS, v);
    if (v[0] !== 1'b0) begin
      chk(v, 32'h0);
      wrap_up();
    end
  endtask
  task automatic chk_st(input logic [7:0] e);
    rd(`NESC_REG_STATUS, v);
    chk(32'(v[15:8]), 32'(e));
  endtask
  initial begin
    repeat (16) @(posedge i_clock);
    i_rstn <= 1'b1;
    rd(8'h1c, v);
    chk(v, 32'h0);
    wr(`NESC_REG_CFG, 32'h0);
    run(NESC_OP_RESET);
    chk_st(8'h60);
    wr(`NESC_REG_CFG, 32'h1);
    run(NESC_OP_RESET);
    chk_st(8'he0);
    for (k = 0; k < 4; k++) begin
      r0 = (k == 0) ? 32'h3ffbf : $random(seed);
      r1 = $random(seed);
      r0[6] = 1'b0;
      r1[6] = 1'b1;
      wr(`NESC_REG_ROW0, r0);
      wr(`NESC_REG_ROW1, r1);
      run(NESC_OP_ERASE1);
      chk_st(8'he0);
      chk(32'(u_nesc_flash_model.blk_q), 32'(r0[17:7]));
      run(NESC_OP_ERASE2);
      chk(32'(u_nesc_flash_model.blk_q), 32'(r1[17:7]));
      chk(32'(u_nesc_flash_model.pl_q), 32'h1);
    end
    run(NESC_OP_STATE);
    chk_st(8'he0);
    for (k = 0; k < 2; k++) begin
      r0 = $random(seed);
      wr(`NESC_REG_FADDR, 32'h80 + k);
      wr(`NESC_REG_FDATA, r0);
      run(NESC_OP_SETF);
      run(NESC_OP_GETF);
      rd(`NESC_REG_FDATA, v);
      chk(v, {30'h0, r0[1:0]});
    end
    run(NESC_OP_RESET);
    run(NESC_OP_GETF);
    rd(`NESC_REG_FDATA, v);
    chk(v, {30'h0, r0[1:0]});
    wr(`NESC_REG_ROW0, r1);
    wr(`NESC_REG_CTRL, 32'(NESC_OP_ERASE1));
    for (k = 0; k < 500 && rbn; k++) @(posedge i_clock);
    chk(32'(rbn), 32'h0);
    repeat (20) @(posedge i_clock);
    wr(`NESC_REG_CTRL, 32'(NESC_OP_GETF));
    run(NESC_OP_RESET);
    chk(32'(v[2]), 32'h1);
    chk_st(8'he0);
    wrap_up();
  end
endmodule // tb_nesc_host
